// File: cpu_regs_pkg.sv
package cpu_regs_pkg;

  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int DATA_W    = 16;
  localparam int LONG_W    = 32;
  localparam int WIDE_W    = 20;
  localparam int FLAG_W    = 11;
  localparam int BANKS     = 2;
  localparam int DATA_REGS = 4;
  localparam int ADDR_REGS = 2;
  localparam int REG_COUNT = 13;

  // ---------------------------------------------------------------
  // Flag word bit positions
  // ---------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [FLAG_W-1:0] FLAG_RST = 11'h000;
  localparam logic [WIDE_W-1:0] PC_RST   = 20'h00000;
  localparam logic [WIDE_W-1:0] VTB_RST  = 20'h00000;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Memory map
  // ---------------------------------------------------------------
  localparam logic [WIDE_W-1:0] MEM_LO    = 20'h00000;
  localparam logic [WIDE_W-1:0] MEM_HI    = 20'hFFFFF;
  localparam logic [WIDE_W-1:0] VEC_LO    = 20'h0FFDC;
  localparam logic [WIDE_W-1:0] VEC_HI    = 20'h0FFFF;
  localparam logic [WIDE_W:0]   ROM_TOP1  = 21'h010000;
  localparam logic [WIDE_W-1:0] RAM_LO    = 20'h00400;
  localparam logic [WIDE_W-1:0] SFR0_LO   = 20'h00000;
  localparam logic [WIDE_W-1:0] SFR0_HI   = 20'h002FF;
  localparam logic [WIDE_W-1:0] SFR1_LO   = 20'h01300;
  localparam logic [WIDE_W-1:0] SFR1_HI   = 20'h0147F;
  localparam int                ROM_BYTES = 49152;
  localparam int                RAM_BYTES = 2560;

  // ---------------------------------------------------------------
  // APB view: register index times four, last index is the stack alias
  // ---------------------------------------------------------------
  localparam int               APB_AW      = 8;
  localparam logic [APB_AW-1:0] APB_LAST_OFS = 8'h34;

  typedef enum logic [3:0] {
    SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3, SEL_ADDR0, SEL_ADDR1, SEL_FRAME,
    SEL_VTB, SEL_PC, SEL_USP, SEL_ISP, SEL_SB, SEL_FLAG, SEL_SP
  } reg_sel_t;

  typedef enum logic [1:0] {SZ_LOW, SZ_HIGH, SZ_WORD, SZ_LONG} size_t;

  typedef enum logic [2:0] {
    RGN_SFR, RGN_RAM, RGN_ROM, RGN_VECTOR, RGN_UNMAPPED
  } region_t;

  typedef struct packed {
    logic              en;
    reg_sel_t          sel;
    size_t             size;
    logic [LONG_W-1:0] data;
  } reg_wr_t;

  typedef struct packed {
    reg_sel_t sel;
    size_t    size;
  } reg_rd_t;

  typedef struct packed {
    logic              en;
    size_t             size;
    logic [LONG_W-1:0] result;
    logic              upd_c;
    logic              carry;
    logic              upd_o;
    logic              overflow;
  } alu_res_t;

  typedef struct packed {
    logic [DATA_REGS-1:0][DATA_W-1:0] data;
    logic [ADDR_REGS-1:0][DATA_W-1:0] addr;
    logic [DATA_W-1:0]                frame;
  } bank_t;

endpackage

// File: cpu_register_set.sv
// Contract
// RULE1 - Thirteen registers, bank duplicated twice
// RULE2 - Bank flag picks bank zero or one
// RULE3 - Data regs 16-bit, byte halves, paired longs
// RULE4 - Address regs 16-bit, pair upper second
// RULE5 - Frame and static base 16-bit
// RULE6 - Vector table base 20-bit
// RULE7 - Program counter 20-bit
// RULE8 - Stack flag picks user or interrupt pointer
// RULE9 - Flag word 11 bits wide
// RULE10 - Carry captures ALU carry or shift-out
// RULE11 - Writers keep debug flag zero
// RULE12 - Zero flag set on zero result
// RULE13 - Sign flag set on negative result
// RULE14 - Overflow flag set on overflow
// RULE15 - Decoder spans one megabyte space
// RULE16 - Fixed vector table at top region
// RULE17 - Program memory ends at 0FFFFh
// RULE18 - Data memory starts at 00400h
// RULE19 - Peripheral areas decoded as two ranges
// RULE20 - Reset clears bank, stack, debug flags
module cpu_register_set
  import cpu_regs_pkg::*;
#(
  parameter int ROM_SIZE = ROM_BYTES,
  parameter int RAM_SIZE = RAM_BYTES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire reg_wr_t           wr_i,
  input  wire reg_rd_t           rd_a_i,
  input  wire reg_rd_t           rd_b_i,
  input  wire alu_res_t          alu_i,
  input  wire logic [WIDE_W-1:0] mem_addr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [LONG_W-1:0] pwdata_i,
  output logic      [LONG_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic      [LONG_W-1:0] rd_a_data_o,
  output logic      [LONG_W-1:0] rd_b_data_o,
  output logic      [FLAG_W-1:0] flag_word_o,
  output logic      [WIDE_W-1:0] pc_o,
  output logic      [WIDE_W-1:0] vector_base_o,
  output logic      [DATA_W-1:0] active_sp_o,
  output region_t                region_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bank_t [BANKS-1:0] bank;
    logic [WIDE_W-1:0] vtb;
    logic [WIDE_W-1:0] pc;
    logic [DATA_W-1:0] user_stack_ptr;
    logic [DATA_W-1:0] interrupt_stack_ptr;
    logic [DATA_W-1:0] sb;
    logic [FLAG_W-1:0] cpu_flag_word;
    logic [LONG_W-1:0] rd_a;
    logic [LONG_W-1:0] rd_b;
    logic [LONG_W-1:0] prdata;
    region_t           region;
  } regs_state_t;

  localparam logic [WIDE_W-1:0] ROM_LO = WIDE_W'(ROM_TOP1 - 21'(ROM_SIZE));
  localparam logic [WIDE_W-1:0] RAM_HI = WIDE_W'(21'(RAM_LO) + 21'(RAM_SIZE) - 21'h000001);

  regs_state_t st;
  regs_state_t next_st;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] merge16(logic [DATA_W-1:0] old, size_t sz,
                                                logic [LONG_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = old;
    case (sz)
      SZ_LOW:  v[7:0]  = d[7:0]; // RULE3
      SZ_HIGH: v[15:8] = d[7:0]; // RULE3
      default: v       = d[15:0];
    endcase
    return v;
  endfunction

  function automatic logic [LONG_W-1:0] shape(logic [DATA_W-1:0] lo, logic [DATA_W-1:0] hi,
                                              size_t sz);
    logic [LONG_W-1:0] v;
    case (sz)
      SZ_LOW:  v = {24'h000000, lo[7:0]};
      SZ_HIGH: v = {24'h000000, lo[15:8]};
      SZ_WORD: v = {16'h0000, lo};
      default: v = {hi, lo}; // RULE3 RULE4
    endcase
    return v;
  endfunction

  function automatic logic [LONG_W-1:0] read_reg(regs_state_t s, reg_sel_t sel, size_t sz);
    bank_t             bk;
    logic [LONG_W-1:0] v;
    bk = s.bank[s.cpu_flag_word[FLG_B]]; // RULE2
    case (sel)
      SEL_DATA0: v = shape(bk.data[0], bk.data[2], sz); // RULE3
      SEL_DATA1: v = shape(bk.data[1], bk.data[3], sz); // RULE3
      SEL_DATA2: v = shape(bk.data[2], WORD_RST, (sz == SZ_LONG) ? SZ_WORD : sz);
      SEL_DATA3: v = shape(bk.data[3], WORD_RST, (sz == SZ_LONG) ? SZ_WORD : sz);
      SEL_ADDR0: v = shape(bk.addr[0], bk.addr[1], sz); // RULE4
      SEL_ADDR1: v = shape(bk.addr[1], WORD_RST, (sz == SZ_LONG) ? SZ_WORD : sz);
      SEL_FRAME: v = {16'h0000, bk.frame}; // RULE5
      SEL_VTB:   v = {12'h000, s.vtb}; // RULE6
      SEL_PC:    v = {12'h000, s.pc}; // RULE7
      SEL_USP:   v = {16'h0000, s.user_stack_ptr};
      SEL_ISP:   v = {16'h0000, s.interrupt_stack_ptr};
      SEL_SB:    v = {16'h0000, s.sb}; // RULE5
      SEL_FLAG:  v = {21'h000000, s.cpu_flag_word}; // RULE9
      SEL_SP:    v = {16'h0000, s.cpu_flag_word[FLG_U] ? s.user_stack_ptr : s.interrupt_stack_ptr}; // RULE8
      default:   v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic regs_state_t write_reg(regs_state_t s, reg_sel_t sel, size_t sz,
                                            logic [LONG_W-1:0] d);
    regs_state_t r;
    logic        b;
    r = s;
    b = s.cpu_flag_word[FLG_B]; // RULE2
    case (sel)
      SEL_DATA0, SEL_DATA1: begin
        r.bank[b].data[sel[0]] = merge16(s.bank[b].data[sel[0]], sz, d); // RULE3
        if (sz == SZ_LONG) begin
          r.bank[b].data[2 + int'(sel[0])] = d[31:16]; // RULE3
        end
      end
      SEL_DATA2, SEL_DATA3: begin
        r.bank[b].data[2 + int'(sel[0])] = merge16(s.bank[b].data[2 + int'(sel[0])], sz, d);
      end
      SEL_ADDR0: begin
        r.bank[b].addr[0] = merge16(s.bank[b].addr[0], sz, d); // RULE4
        if (sz == SZ_LONG) begin
          r.bank[b].addr[1] = d[31:16]; // RULE4
        end
      end
      SEL_ADDR1: r.bank[b].addr[1] = merge16(s.bank[b].addr[1], sz, d);
      SEL_FRAME: r.bank[b].frame = merge16(s.bank[b].frame, sz, d); // RULE5
      SEL_VTB:   r.vtb = d[WIDE_W-1:0]; // RULE6
      SEL_PC:    r.pc = d[WIDE_W-1:0]; // RULE7
      SEL_USP:   r.user_stack_ptr = merge16(s.user_stack_ptr, sz, d);
      SEL_ISP:   r.interrupt_stack_ptr = merge16(s.interrupt_stack_ptr, sz, d);
      SEL_SB:    r.sb = merge16(s.sb, sz, d); // RULE5
      SEL_FLAG: begin
        r.cpu_flag_word        = d[FLAG_W-1:0]; // RULE9
        r.cpu_flag_word[FLG_D] = 1'b0; // RULE11
      end
      SEL_SP: begin
        if (s.cpu_flag_word[FLG_U]) begin // RULE8
          r.user_stack_ptr = merge16(s.user_stack_ptr, sz, d);
        end else begin
          r.interrupt_stack_ptr = merge16(s.interrupt_stack_ptr, sz, d);
        end
      end
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic res_zero(logic [LONG_W-1:0] res, size_t sz);
    case (sz)
      SZ_LOW, SZ_HIGH: return res[7:0] == 8'h00;
      SZ_WORD:         return res[15:0] == 16'h0000;
      default:         return res == 32'h00000000;
    endcase
  endfunction

  function automatic logic res_neg(logic [LONG_W-1:0] res, size_t sz);
    case (sz)
      SZ_LOW, SZ_HIGH: return res[7];
      SZ_WORD:         return res[15];
      default:         return res[31];
    endcase
  endfunction

  function automatic region_t decode(logic [WIDE_W-1:0] a);
    // Vector table sits inside program memory, so it is checked first
    if (a >= VEC_LO && a <= VEC_HI) begin // RULE16
      return RGN_VECTOR;
    end else if ((a >= SFR0_LO && a <= SFR0_HI) || (a >= SFR1_LO && a <= SFR1_HI)) begin
      return RGN_SFR; // RULE19
    end else if (a >= RAM_LO && a <= RAM_HI) begin // RULE18
      return RGN_RAM;
    end else if (a >= ROM_LO && a <= VEC_HI) begin // RULE17
      return RGN_ROM;
    end else begin
      return RGN_UNMAPPED; // RULE15
    end
  endfunction

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic apb_hit;
  logic apb_setup;
  logic apb_write;

  assign apb_hit   = (paddr_i[1:0] == 2'b00) && (paddr_i <= APB_LAST_OFS);
  assign apb_setup = psel_i && !penable_i;
  // Core writes own the register file; bus access waits while one is pending
  assign pready_o  = !wr_i.en;
  assign pslverr_o = psel_i && penable_i && !apb_hit;
  assign apb_write = psel_i && penable_i && pwrite_i && apb_hit && pready_o;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (apb_write) begin
      next_st = write_reg(next_st, reg_sel_t'(paddr_i[5:2]), SZ_LONG, pwdata_i);
    end
    if (wr_i.en) begin
      next_st = write_reg(next_st, wr_i.sel, wr_i.size, wr_i.data);
    end
    // Core flag-word write takes precedence over ALU flag results; ALU results override a bus write
    if (alu_i.en && !(wr_i.en && wr_i.sel == SEL_FLAG)) begin
      next_st.cpu_flag_word[FLG_Z] = res_zero(alu_i.result, alu_i.size); // RULE12
      next_st.cpu_flag_word[FLG_S] = res_neg(alu_i.result, alu_i.size); // RULE13
      if (alu_i.upd_c) begin
        next_st.cpu_flag_word[FLG_C] = alu_i.carry; // RULE10
      end
      if (alu_i.upd_o) begin
        next_st.cpu_flag_word[FLG_O] = alu_i.overflow; // RULE14
      end
    end
    next_st.rd_a   = read_reg(st, rd_a_i.sel, rd_a_i.size);
    next_st.rd_b   = read_reg(st, rd_b_i.sel, rd_b_i.size);
    next_st.region = decode(mem_addr_i);
    if (apb_setup) begin
      next_st.prdata = apb_hit ? read_reg(st, reg_sel_t'(paddr_i[5:2]), SZ_LONG)
                               : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < BANKS; i++) begin // RULE1
        st.bank[i] <= '0;
      end
      st.vtb    <= VTB_RST;
      st.pc     <= PC_RST;
      st.user_stack_ptr    <= WORD_RST;
      st.interrupt_stack_ptr    <= WORD_RST;
      st.sb     <= WORD_RST;
      st.cpu_flag_word    <= FLAG_RST; // RULE20
      st.rd_a   <= 32'h00000000;
      st.rd_b   <= 32'h00000000;
      st.prdata <= 32'h00000000;
      st.region <= RGN_SFR;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o      = st.prdata;
  assign rd_a_data_o   = st.rd_a;
  assign rd_b_data_o   = st.rd_b;
  assign flag_word_o   = st.cpu_flag_word;
  assign pc_o          = st.pc;
  assign vector_base_o = st.vtb;
  assign active_sp_o   = st.cpu_flag_word[FLG_U] ? st.user_stack_ptr : st.interrupt_stack_ptr; // RULE8
  assign region_o      = st.region;

endmodule

// File: cpu_register_set_sva.sv
module cpu_register_set_sva
  import cpu_regs_pkg::*;
#(
  parameter int ROM_SIZE = ROM_BYTES,
  parameter int RAM_SIZE = RAM_BYTES
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire reg_wr_t           wr_i,
  input wire alu_res_t          alu_i,
  input wire logic [WIDE_W-1:0] mem_addr_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [FLAG_W-1:0] flag_word_o,
  input wire region_t           region_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam int RAM_END  = int'(RAM_LO) + RAM_SIZE;
  localparam int ROM_BASE = int'(ROM_TOP1) - ROM_SIZE;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Core flag write wins, so the ALU update is only checked without one
  wire logic alu_ok = alu_i.en && !(wr_i.en && wr_i.sel == SEL_FLAG);
  // A bus write may target the flag word too, so hold is only checked without one
  wire logic apb_wr = psel_i && penable_i && pwrite_i;
  wire logic in_sfr = mem_addr_i <= SFR0_HI || (mem_addr_i >= SFR1_LO && mem_addr_i <= SFR1_HI);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_vector_region: assert property (mem_addr_i >= VEC_LO && mem_addr_i <= VEC_HI
    |=> region_o == RGN_VECTOR) else $error("vector decode");
  a_sfr_region: assert property (in_sfr |=> region_o == RGN_SFR) else $error("sfr decode");
  a_ram_region: assert property (mem_addr_i >= RAM_LO && mem_addr_i < RAM_END && !in_sfr
    |=> region_o == RGN_RAM) else $error("ram decode");
  a_rom_region: assert property (mem_addr_i >= ROM_BASE && mem_addr_i < VEC_LO && !in_sfr
    && mem_addr_i >= RAM_END |=> region_o == RGN_ROM) else $error("rom decode");
  a_top_unmapped: assert property (mem_addr_i > VEC_HI
    |=> region_o == RGN_UNMAPPED) else $error("top decode");
  a_zero_flag: assert property (alu_ok && alu_i.size == SZ_WORD
    && alu_i.result[15:0] == 16'h0 |=> flag_word_o[FLG_Z] && !flag_word_o[FLG_S])
    else $error("zero flag");
  a_sign_flag: assert property (alu_ok && alu_i.size == SZ_LONG
    |=> flag_word_o[FLG_S] == $past(alu_i.result[31])) else $error("sign flag");
  a_carry_flag: assert property (alu_ok && alu_i.upd_c
    |=> flag_word_o[FLG_C] == $past(alu_i.carry)) else $error("carry flag");
  a_ovf_flag: assert property (alu_ok && alu_i.upd_o
    |=> flag_word_o[FLG_O] == $past(alu_i.overflow)) else $error("overflow flag");
  a_debug_low: assert property (!flag_word_o[FLG_D]) else $error("debug flag set");
  a_flag_hold: assert property (!alu_i.en && !wr_i.en && !apb_wr
    |=> $stable(flag_word_o)) else $error("flag word moved");
  c_alu_zero: cover property (alu_ok && alu_i.result == 32'h0);
  c_vector: cover property (region_o == RGN_VECTOR);
  c_flag_write: cover property (wr_i.en && wr_i.sel == SEL_FLAG);
endmodule

bind cpu_register_set cpu_register_set_sva #(.ROM_SIZE(ROM_SIZE), .RAM_SIZE(RAM_SIZE))
  i_cpu_register_set_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .alu_i(alu_i),
  .mem_addr_i(mem_addr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .flag_word_o(flag_word_o), .region_o(region_o));

// File: cpu_core_model.sv
module cpu_core_model
  import cpu_regs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [LONG_W-1:0] rd_a_data_i,
  output reg_wr_t                wr_o,
  output alu_res_t               alu_o,
  output reg_rd_t                rd_a_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = '0;
    alu_o = '0;
    rd_a_o = '0;
  end
  // ---------------------------------------------------------------
  // Execution unit requests
  // ---------------------------------------------------------------
  task automatic core_write(input reg_sel_t s, input size_t z, input logic [LONG_W-1:0] d);
    @(posedge clk_i);
    wr_o <= '{1'b1, s, z, (s == SEL_FLAG) ? (d & ~(32'h1 << FLG_D)) : d};
    @(posedge clk_i);
    wr_o.en <= 1'b0;
    // Idle bus shows inverted data so a stale value cannot pass
    wr_o.data <= ~d;
  endtask
  task automatic alu_op(input alu_res_t a);
    @(posedge clk_i);
    alu_o <= a;
    @(posedge clk_i);
    alu_o.en <= 1'b0;
  endtask
  task automatic core_read(input reg_sel_t s, input size_t z, output logic [LONG_W-1:0] q);
    @(posedge clk_i);
    rd_a_o <= '{s, z};
    @(posedge clk_i);
    #1 q = rd_a_data_i;
  endtask
endmodule

// File: test_cpu_register_set.sv
module test_cpu_register_set
  import cpu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0, rst_n_i = 1'b0;
  logic              psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [APB_AW-1:0] paddr_i = '0;
  logic [LONG_W-1:0] pwdata_i = '0, prdata_o, rd_a_data_o, rd_b_data_o, q;
  logic [WIDE_W-1:0] mem_addr_i = '0, pc_o, vector_base_o;
  logic [FLAG_W-1:0] flag_word_o;
  logic [DATA_W-1:0] active_sp_o;
  logic              pready_o, pslverr_o, e;
  reg_wr_t           wr_i;
  reg_rd_t           rd_a_i;
  reg_rd_t           rd_b_i = '0;
  alu_res_t          alu_i;
  region_t           region_o;
  int                num_errors = 0, comparisons = 0, waits = 0;
  logic [7:0]  wa [6] = '{8'h18, 8'h2C, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [31:0] wd [6] = '{32'hFFFF1234, 32'hFFFF5678, 32'hFFFFFFFF, 32'hFFFABCDE,
                         32'hFFFF1111, 32'hFFFF2222};
  int          ww [6] = '{16, 16, 20, 20, 16, 16};
  alu_res_t    at [3] = '{'{1'b1, SZ_WORD, 32'h00010000, 1'b1, 1'b1, 1'b1, 1'b0},
                         '{1'b1, SZ_LOW, 32'h00000080, 1'b0, 1'b0, 1'b1, 1'b1},
                         '{1'b1, SZ_LONG, 32'h80000000, 1'b1, 1'b0, 1'b0, 1'b0}};
  logic [3:0]  af [3] = '{4'b0011, 4'b1101, 4'b1100};
  logic [19:0] da [10] = '{20'h00000, 20'h002FF, 20'h00300, 20'h00400, 20'h00DFF,
                          20'h0147F, 20'h04000, 20'h0FFDB, 20'h0FFDC, 20'hFFFFF};
  region_t     dr [10] = '{RGN_SFR, RGN_SFR, RGN_UNMAPPED, RGN_RAM, RGN_RAM, RGN_SFR,
                          RGN_ROM, RGN_ROM, RGN_VECTOR, RGN_UNMAPPED};
  cpu_register_set i_cpu_register_set (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i),
    .rd_a_i(rd_a_i), .rd_b_i(rd_b_i), .alu_i(alu_i), .mem_addr_i(mem_addr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rd_a_data_o(rd_a_data_o), .rd_b_data_o(rd_b_data_o), .flag_word_o(flag_word_o),
    .pc_o(pc_o),
    .vector_base_o(vector_base_o), .active_sp_o(active_sp_o), .region_o(region_o));
  cpu_core_model i_cpu_core_model (.clk_i(clk_i), .rd_a_data_i(rd_a_data_o), .wr_o(wr_i),
    .alu_o(alu_i), .rd_a_o(rd_a_i));
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Core writes stall the access; only the watchdog ends a hang here
    waits = 0;
    do begin
      @(posedge clk_i);
      waits++;
    end while (pready_o !== 1'b1);
    r = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #50000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(32'(flag_word_o), 32'h0);
    apb(1'b1, 8'h00, 32'h87654321, q, e);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h87654321);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk(q, 32'h00008765);
    apb(1'b1, 8'h10, 32'hA1A1B0B0, q, e);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk(q, 32'h0000A1A1);
    @(posedge clk_i);
    rd_b_i <= '{SEL_ADDR0, SZ_LONG};
    @(posedge clk_i);
    #1 chk(rd_b_data_o, 32'hA1A1B0B0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, wa[i], wd[i], q, e);
      apb(1'b0, wa[i], 32'h0, q, e);
      chk(q, wd[i] & ~(32'hFFFFFFFF << ww[i]));
    end
    chk(32'(active_sp_o), 32'h2222);
    chk(32'(pc_o) + 32'(vector_base_o), 32'h000ABCDE + 32'h000FFFFF);
    apb(1'b1, 8'h30, 32'h000007FF, q, e);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk(q, 32'h000007FD);
    chk(32'(active_sp_o), 32'h1111);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, 8'h00, 32'h1, q, e);
    apb(1'b1, 8'h30, 32'h0, q, e);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h87654321);
    apb(1'b0, 8'h38, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    i_cpu_core_model.core_write(SEL_DATA1, SZ_WORD, 32'h0000BEEF);
    i_cpu_core_model.core_write(SEL_DATA1, SZ_HIGH, 32'h00000012);
    i_cpu_core_model.core_read(SEL_DATA1, SZ_LOW, q);
    chk(q, 32'h000000EF);
    i_cpu_core_model.core_read(SEL_DATA1, SZ_HIGH, q);
    chk(q, 32'h00000012);
    fork
      apb(1'b0, 8'h04, 32'h0, q, e);
      begin
        @(posedge clk_i);
        i_cpu_core_model.core_write(SEL_SB, SZ_WORD, 32'h00004321);
      end
    join
    chk(q, 32'h000012EF);
    chk(32'(waits), 32'h00000002);
    apb(1'b0, 8'h2C, 32'h0, q, e);
    chk(q, 32'h00004321);
    for (int i = 0; i < 3; i++) begin
      i_cpu_core_model.alu_op(at[i]);
      #1 chk(32'({flag_word_o[FLG_O], flag_word_o[FLG_S:FLG_Z], flag_word_o[FLG_C]}),
             32'(af[i]));
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      mem_addr_i <= da[i];
      @(posedge clk_i);
      #1 chk(32'(region_o), 32'(dr[i]));
    end
    complete_run;
  end
endmodule
